/* hdl/selfid_regs_pkg.sv */
// constants and register layout for the self-id and upper iso mask registers
package selfid_regs_pkg;
    localparam logic [7:0] base_off      = 8'h64;
    localparam logic [7:0] count_off     = 8'h68;
    localparam logic [7:0] mask_set_off  = 8'h70;
    localparam logic [7:0] mask_clr_off  = 8'h74;
    localparam logic [7:0] ctrl_off      = 8'h90;
    localparam logic [7:0] irq_stat_off  = 8'h94;
    localparam logic [7:0] irq_mask_off  = 8'h98;
    localparam int base_lsb   = 11;
    localparam int fault_bit  = 31;
    localparam int gen_lsb    = 16;
    localparam int size_lsb   = 2;
    localparam int reinit_bit = 0;
    localparam int size_w     = 9;
    localparam int gen_w      = 8;
    localparam int irq_w      = 3;
    localparam int irq_reset_ev = 0;
    localparam int irq_done_ev  = 1;
    localparam int irq_fault_ev = 2;
    localparam logic [3:0] reinit_cycles = 4'h4;
endpackage

/* hdl/selfid_regs.sv */
// register bank: self-id buffer base, self-id status count, upper iso mask
`timescale 1ns/100ps
`default_nettype none
module selfid_regs (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // self-id receive path
    input  wire logic        bus_reset_seen,
    input  wire logic        rx_start,
    input  wire logic        quadlet_written,
    input  wire logic        rx_done,
    input  wire logic        rx_data_error,
    input  wire logic        host_write_error,
    // to the dma writer and iso receive filter, plus reinit busy and interrupt
    output logic      [31:0] self_id_write_addr,
    output logic      [31:0] upper_iso_receive_filter,
    output logic             soft_reset_busy,
    output logic             irq
);
    localparam int sw = selfid_regs_pkg::size_w;
    localparam int iw = selfid_regs_pkg::irq_w;

    logic [31:11] base_hi;
    logic         self_id_fault_flag;
    logic [7:0]   bus_reset_generation_count;
    logic [sw-1:0] self_id_quadlet_count;
    logic [iw-1:0] irq_stat;
    logic [iw-1:0] irq_mask;
    logic [3:0]   reinit_cnt;
    logic         rx_err_seen;
    logic         wr_acc;
    logic         soft_clr;
    logic [iw-1:0] ev;

    assign pready  = 1'b1;  // zero wait state slave
    assign wr_acc  = psel && penable && pwrite;
    assign soft_reset_busy = (reinit_cnt != 4'h0);
    assign soft_clr = soft_reset_busy;

    // decode of an access address, for reads and writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // unmapped addresses flag an error but complete normally
    always_comb begin
        pslverr = psel && penable &&
            !(hit(paddr, selfid_regs_pkg::base_off) ||
              hit(paddr, selfid_regs_pkg::count_off) ||
              hit(paddr, selfid_regs_pkg::mask_set_off) ||
              hit(paddr, selfid_regs_pkg::mask_clr_off) ||
              hit(paddr, selfid_regs_pkg::ctrl_off) ||
              hit(paddr, selfid_regs_pkg::irq_stat_off) ||
              hit(paddr, selfid_regs_pkg::irq_mask_off));
    end

    // software reinit: held busy for a few cycles, reads back set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reinit_cnt <= 4'h0;
        end else if (wr_acc && hit(paddr, selfid_regs_pkg::ctrl_off) &&
                     pwdata[selfid_regs_pkg::reinit_bit]) begin
            reinit_cnt <= selfid_regs_pkg::reinit_cycles;
        end else if (reinit_cnt != 4'h0) begin
            reinit_cnt <= reinit_cnt - 4'h1;
        end
    end

    // buffer base, only the 2 KB aligned part is stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_hi <= '0;
        end else if (soft_clr) begin
            base_hi <= '0;
        end else if (wr_acc && hit(paddr, selfid_regs_pkg::base_off)) begin
            base_hi <= pwdata[31:11];
        end
    end

    // dma write address: base plus quadlets already stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            self_id_write_addr <= '0;
        end else begin
            self_id_write_addr <= {base_hi, 11'h000} |
                {21'h000000, self_id_quadlet_count, 2'b00};
        end
    end

    // generation counter; 8-bit add wraps naturally at 255
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_reset_generation_count <= '0;
        end else if (soft_clr) begin
            bus_reset_generation_count <= '0;
        end else if (bus_reset_seen) begin
            bus_reset_generation_count <=
                bus_reset_generation_count + 8'h01;
        end
    end

    // quadlet count; the start of reception wins over a write pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            self_id_quadlet_count <= '0;
        end else if (soft_clr || rx_start) begin
            self_id_quadlet_count <= '0;
        end else if (quadlet_written) begin
            self_id_quadlet_count <= self_id_quadlet_count + 9'h001;
        end
    end

    // errors seen during the reception in progress
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_err_seen <= 1'b0;
        end else if (soft_clr || rx_start) begin
            rx_err_seen <= 1'b0;
        end else if (rx_data_error || host_write_error) begin
            rx_err_seen <= 1'b1;
        end
    end

    // fault flag: set at once on error, cleared by a clean finish or by a reinit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            self_id_fault_flag <= 1'b0;
        end else if (soft_clr) begin
            self_id_fault_flag <= 1'b0;
        end else if (rx_data_error || host_write_error) begin
            self_id_fault_flag <= 1'b1;
        end else if (rx_done && !rx_err_seen) begin
            self_id_fault_flag <= 1'b0;
        end
    end

    // upper mask, set and clear ports; bit n gates channel 32+n
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_iso_receive_filter <= '0;
        end else if (soft_clr) begin
            upper_iso_receive_filter <= '0;
        end else if (wr_acc && hit(paddr, selfid_regs_pkg::mask_set_off)) begin
            upper_iso_receive_filter <=
                upper_iso_receive_filter | pwdata;
        end else if (wr_acc && hit(paddr, selfid_regs_pkg::mask_clr_off)) begin
            upper_iso_receive_filter <=
                upper_iso_receive_filter & ~pwdata;
        end
    end

    // interrupt events; a new event wins over a write-one clear
    assign ev = {rx_data_error || host_write_error, rx_done, bus_reset_seen};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else if (soft_clr) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            if (wr_acc && hit(paddr, selfid_regs_pkg::irq_stat_off)) begin
                irq_stat <= (irq_stat & ~pwdata[iw-1:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            if (wr_acc && hit(paddr, selfid_regs_pkg::irq_mask_off)) begin
                irq_mask <= pwdata[iw-1:0];
            end
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // read mux; reserved bits stay zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            unique case (paddr)
                selfid_regs_pkg::base_off:  prdata = {base_hi, 11'h000};
                selfid_regs_pkg::count_off: prdata = {self_id_fault_flag,
                    7'h00, bus_reset_generation_count, 5'h00,
                    self_id_quadlet_count, 2'b00};
                selfid_regs_pkg::mask_set_off,
                selfid_regs_pkg::mask_clr_off:
                    prdata = upper_iso_receive_filter;
                selfid_regs_pkg::ctrl_off:
                    prdata = {31'h0000_0000, soft_reset_busy};
                selfid_regs_pkg::irq_stat_off:
                    prdata = {29'h0000_0000, irq_stat};
                selfid_regs_pkg::irq_mask_off:
                    prdata = {29'h0000_0000, irq_mask};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // checks
    a_gen_increments: assert property (@(posedge pclk) disable iff (!presetn)
        bus_reset_seen && !soft_clr |=> bus_reset_generation_count ==
        $past(bus_reset_generation_count) + 8'h01)
        else $error("generation did not advance");
    a_gen_wraps: assert property (@(posedge pclk) disable iff (!presetn)
        bus_reset_seen && !soft_clr && bus_reset_generation_count == 8'hff
        |=> bus_reset_generation_count == 8'h00)
        else $error("generation did not wrap");
    a_size_clears: assert property (@(posedge pclk) disable iff (!presetn)
        rx_start |=> self_id_quadlet_count == '0)
        else $error("size not cleared at start");
    a_fault_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_data_error || host_write_error) && !soft_clr
        |=> self_id_fault_flag)
        else $error("fault flag not raised");
    a_fault_clears: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done && !rx_err_seen && !rx_data_error && !host_write_error
        |=> !self_id_fault_flag)
        else $error("fault flag not cleared");
    a_base_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !pwrite && paddr == selfid_regs_pkg::base_off
        |-> prdata[10:0] == 11'h000)
        else $error("base low bits not zero");
    a_mask_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == selfid_regs_pkg::mask_set_off && !soft_clr
        |=> (upper_iso_receive_filter & $past(pwdata)) == $past(pwdata))
        else $error("mask set failed");
    a_mask_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !pwrite && paddr == selfid_regs_pkg::mask_clr_off
        |-> prdata == upper_iso_receive_filter)
        else $error("mask read mismatch");
    a_reinit_clear: assert property (@(posedge pclk) disable iff (!presetn)
        soft_clr |=> upper_iso_receive_filter == '0 && base_hi == '0)
        else $error("reinit did not clear");

    // the checks below all run on the bus clock and sleep in reset
    default clocking cb_pclk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // named steps shared by the properties below
    sequence s_reinit_req;
        wr_acc && paddr == selfid_regs_pkg::ctrl_off &&
            pwdata[selfid_regs_pkg::reinit_bit];
    endsequence
    // reinit length is fixed; a reload while busy only stretches it
    sequence s_busy_run;
        soft_reset_busy [*4];
    endsequence
    sequence s_count_read;
        psel && !pwrite && paddr == selfid_regs_pkg::count_off;
    endsequence
    sequence s_base_read;
        psel && !pwrite && paddr == selfid_regs_pkg::base_off;
    endsequence
    // a quadlet pulse only counts when no start or reinit competes
    sequence s_quad_step;
        quadlet_written && !rx_start && !soft_clr;
    endsequence

    // software reinit holds busy for its whole window
    a_reinit_busy: assert property (
        s_reinit_req |=> s_busy_run)
        else $error("reinit busy window too short");

    a_reinit_done: assert property (
        reinit_cnt == 4'h1 && !(wr_acc && paddr == selfid_regs_pkg::ctrl_off)
        |=> !soft_reset_busy)
        else $error("reinit busy did not end");

    a_reinit_reads: assert property (
        psel && !pwrite && paddr == selfid_regs_pkg::ctrl_off
        |-> prdata[0] == soft_reset_busy)
        else $error("reinit bit reads wrong");

    // the reinit clears status as a hardware reset would
    a_reinit_status: assert property (
        soft_clr |=> bus_reset_generation_count == 8'h00 &&
        self_id_quadlet_count == '0 && !self_id_fault_flag &&
        irq_stat == '0)
        else $error("reinit left status set");

    // count register fields and reserved holes
    a_count_holes: assert property (
        s_count_read |-> prdata[30:24] == 7'h00 &&
        prdata[15:11] == 5'h00 && prdata[1:0] == 2'h0)
        else $error("count reserved bits not zero");

    a_count_fields: assert property (
        s_count_read |-> prdata[31] == self_id_fault_flag &&
        prdata[23:16] == bus_reset_generation_count &&
        prdata[10:2] == self_id_quadlet_count)
        else $error("count fields misplaced");

    // generation counter holds between bus resets
    a_gen_holds: assert property (
        !bus_reset_seen && !soft_clr
        |=> $stable(bus_reset_generation_count))
        else $error("generation moved without a bus reset");

    a_size_counts: assert property (
        s_quad_step |=> self_id_quadlet_count ==
        $past(self_id_quadlet_count) + 9'h001)
        else $error("quadlet count did not advance");

    a_size_holds: assert property (
        !quadlet_written && !rx_start && !soft_clr
        |=> $stable(self_id_quadlet_count))
        else $error("quadlet count moved without a write");

    // fault flag is sticky until a clean reception ends or a reinit clears it
    a_fault_holds: assert property (
        self_id_fault_flag && !rx_done && !soft_clr
        |=> self_id_fault_flag)
        else $error("fault flag dropped early");

    a_fault_sticky: assert property (
        rx_done && rx_err_seen && !soft_clr |=> self_id_fault_flag)
        else $error("fault cleared after a bad reception");

    a_fault_quiet: assert property (
        !self_id_fault_flag && !rx_data_error && !host_write_error
        |=> !self_id_fault_flag)
        else $error("fault raised without an error");

    // buffer base keeps only the aligned part of a write
    a_base_write: assert property (
        wr_acc && paddr == selfid_regs_pkg::base_off && !soft_clr
        |=> {base_hi, 11'h000} == ($past(pwdata) & 32'hffff_f800))
        else $error("base write not stored");

    a_base_read: assert property (
        s_base_read |-> prdata[31:11] == base_hi)
        else $error("base read mismatch");

    // dma address follows base and quadlet count one cycle late
    a_addr_base: assert property (
        1'b1 |=> self_id_write_addr[31:11] == $past(base_hi))
        else $error("write address lost the base");

    a_addr_offset: assert property (
        1'b1 |=> self_id_write_addr[10:0] ==
        {$past(self_id_quadlet_count), 2'h0})
        else $error("write address offset wrong");

    // upper mask: set and clear ports touch only the ones written
    a_mask_clear: assert property (
        wr_acc && paddr == selfid_regs_pkg::mask_clr_off && !soft_clr
        |=> (upper_iso_receive_filter & $past(pwdata)) == 32'h0000_0000)
        else $error("mask clear failed");

    a_mask_keeps: assert property (
        wr_acc && paddr == selfid_regs_pkg::mask_set_off && !soft_clr
        |=> (upper_iso_receive_filter & ~$past(pwdata)) ==
        ($past(upper_iso_receive_filter) & ~$past(pwdata)))
        else $error("mask set disturbed other bits");

    a_mask_idle: assert property (
        !(wr_acc && paddr == selfid_regs_pkg::mask_set_off) &&
        !(wr_acc && paddr == selfid_regs_pkg::mask_clr_off) && !soft_clr
        |=> $stable(upper_iso_receive_filter))
        else $error("mask moved without a port write");

    a_mask_set_read: assert property (
        psel && !pwrite && paddr == selfid_regs_pkg::mask_set_off
        |-> prdata == upper_iso_receive_filter)
        else $error("mask set port read mismatch");

    // interrupt status catches the bus reset and fault events
    a_irq_catches: assert property (
        bus_reset_seen && !soft_clr
        |=> irq_stat[selfid_regs_pkg::irq_reset_ev])
        else $error("bus reset event not latched");

    a_irq_fault: assert property (
        (rx_data_error || host_write_error) && !soft_clr
        |=> irq_stat[selfid_regs_pkg::irq_fault_ev])
        else $error("fault event not latched");

    // unmapped access completes with an error flag and no data
    a_slverr_hole: assert property (
        psel && penable && paddr == 8'h80 |-> pslverr && prdata == '0)
        else $error("unmapped access not flagged");
endmodule // selfid_regs
`default_nettype wire

/* bench/selfid_rx_model.sv */
// model of the self-id receive path driving event pulses
`timescale 1ns/100ps
`default_nettype none
module selfid_rx_model (
    // clock
    input  wire logic pclk,
    // event pulses
    output logic      bus_reset_seen,
    output logic      rx_start,
    output logic      quadlet_written,
    output logic      rx_done,
    output logic      rx_data_error,
    output logic      host_write_error
);
    logic [5:0] ev;
    // one bundle so a pulse touches exactly one bit
    assign {host_write_error, rx_data_error, rx_done,
            quadlet_written, rx_start, bus_reset_seen} = ev;
    initial ev = 6'h00;
    // one-cycle pulse launched just after an edge
    task pulse(input int k);
        @(posedge pclk);
        ev[k] <= 1'b1;
        @(posedge pclk);
        ev[k] <= 1'b0;
    endtask
    // one generation; errors land before completion so they win
    task frame(input int nq, input logic [1:0] fe);
        pulse(0);
        pulse(1);
        repeat (nq) pulse(2);
        if (fe[0]) pulse(4);
        if (fe[1]) pulse(5);
        pulse(3);
    endtask
endmodule // selfid_rx_model
`default_nettype wire

/* bench/tb_selfid_regs.sv */
// testbench for the self-id and upper iso mask register bank
`timescale 1ns/100ps
`default_nettype none
module tb_selfid_regs;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, wa, filt;
    logic        err, busy, irq, brs, rxs, qw, rxd, rde, hwe;
    int          error_cnt, total_checks, gen, i;
    int          nq[4] = '{3, 2, 1, 1};
    logic [1:0]  fe[4] = '{2'h0, 2'h1, 2'h0, 2'h2};
    selfid_rx_model rx_u (.pclk(pclk), .bus_reset_seen(brs),
        .rx_start(rxs), .quadlet_written(qw), .rx_done(rxd),
        .rx_data_error(rde), .host_write_error(hwe));
    selfid_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_reset_seen(brs), .rx_start(rxs),
        .quadlet_written(qw), .rx_done(rxd), .rx_data_error(rde),
        .host_write_error(hwe), .self_id_write_addr(wa),
        .upper_iso_receive_filter(filt), .soft_reset_busy(busy),
        .irq(irq));
    task wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // setup then access; held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            error_cnt++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] cnt_exp(logic f, int n);
        return {f, 7'h00, gen[7:0], 5'h00, n[8:0], 2'b00};
    endfunction
    task t_selfid();
        apb(1'b1, 8'h64, 32'hffffffff);
        apb(1'b0, 8'h64, 32'h0);
        chk(rd, 32'hfffff800, "base");
        for (i = 0; i < 4; i++) begin
            rx_u.frame(nq[i], fe[i]);
            gen++;
            apb(1'b1, 8'h68, 32'hffffffff);
            apb(1'b0, 8'h68, 32'h0);
            chk(rd, cnt_exp(|fe[i], nq[i]), "count");
            chk(wa, 32'hfffff800 + 4 * nq[i], "write addr");
        end
        while (gen % 256 != 255) begin
            rx_u.pulse(0);
            gen++;
        end
        apb(1'b0, 8'h68, 32'h0);
        chk(rd[23:16], 8'hff, "gen top");
        rx_u.pulse(0);
        apb(1'b0, 8'h68, 32'h0);
        chk(rd[23:16], 8'h00, "gen wrap");
        $display("selfid test done");
    endtask
    task t_mask();
        apb(1'b1, 8'h70, 32'h80000001);
        apb(1'b0, 8'h70, 32'h0);
        chk(rd, 32'h80000001, "mask set read");
        apb(1'b0, 8'h74, 32'h0);
        chk(rd, 32'h80000001, "mask clr read");
        chk(filt, 32'h80000001, "filter");
        apb(1'b1, 8'h74, 32'h80000000);
        apb(1'b0, 8'h70, 32'h0);
        chk(rd, 32'h00000001, "mask cleared");
        $display("mask test done");
    endtask
    task t_irq();
        apb(1'b1, selfid_regs_pkg::irq_mask_off, 32'h7);
        apb(1'b0, selfid_regs_pkg::irq_stat_off, 32'h0);
        chk(rd, 32'h7, "irq status");
        #1 chk(irq, 1'b1, "irq up");
        apb(1'b1, selfid_regs_pkg::irq_stat_off, 32'h7);
        #1 chk(irq, 1'b0, "irq cleared");
        apb(1'b1, selfid_regs_pkg::irq_mask_off, 32'h0);
        rx_u.pulse(0);
        apb(1'b0, selfid_regs_pkg::irq_stat_off, 32'h0);
        chk(rd, 32'h1, "irq sticky");
        chk(irq, 1'b0, "irq masked");
        apb(1'b0, 8'h80, 32'h0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped");
        $display("irq test done");
    endtask
    task t_reinit();
        apb(1'b1, selfid_regs_pkg::ctrl_off, 32'h1);
        #1 chk(busy, 1'b1, "reinit busy");
        for (i = 0; i < 20 && busy !== 1'b0; i++)
            @(posedge pclk);
        chk(busy, 1'b0, "reinit end");
        apb(1'b0, 8'h70, 32'h0);
        chk(rd, 32'h0, "mask reinit");
        apb(1'b0, 8'h64, 32'h0);
        chk(rd, 32'h0, "base reinit");
        apb(1'b0, 8'h68, 32'h0);
        chk(rd, 32'h0, "count reinit");
        $display("reinit test done");
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        error_cnt = 0;
        total_checks = 0;
        gen = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h68, 32'h0);
        chk(rd, 32'h0, "count reset");
        t_selfid();
        t_mask();
        t_irq();
        t_reinit();
        wrap_up();
    end
endmodule // tb_selfid_regs
`default_nettype wire
